// ==== src/tim_pkg.sv ====
// constants, tables and types shared by the interleave and mixer logic
package tim_pkg;
    typedef enum logic [1:0] {TIM_RD_IDLE = 2'b01, TIM_RD_RUN = 2'b10} tim_rd_state_t;
    typedef enum logic [1:0] {TIM_PAT_STD = 2'h0, TIM_PAT_COMP1 = 2'h1, TIM_PAT_COMP2 = 2'h2}
        tim_pattern_t;
    localparam int TIM_IL_AW = 14;
    localparam int TIM_MX_AW = 16;
    // block sizes 762 (n=5) and 12282 (n=9)
    localparam logic [13:0] TIM_BLK_SMALL = 14'h02FA;
    localparam logic [13:0] TIM_BLK_LARGE = 14'h2FFA;
    localparam logic [13:0] TIM_CNT_START = 14'h0000;
    // signalling block: 3840 bits, step 61, selector 0
    localparam logic [15:0] TIM_SIG_LEN = 16'h0F00;
    localparam logic [7:0] TIM_SIG_STEP = 8'h3D;
    localparam logic [5:0] TIM_SIG_SELECTOR = 6'h00;
    localparam logic [5:0] TIM_SEL_FIRST_RSV = 6'h1C;
    localparam logic [4:0] TIM_LUT5 [32] = '{5'h1B, 5'h03, 5'h01, 5'h0F, 5'h0D, 5'h11, 5'h17,
        5'h0D, 5'h09, 5'h03, 5'h0F, 5'h03, 5'h0D, 5'h01, 5'h0D, 5'h1D, 5'h15, 5'h13, 5'h01,
        5'h03, 5'h1D, 5'h11, 5'h19, 5'h1D, 5'h09, 5'h0D, 5'h17, 5'h0D, 5'h0D, 5'h01, 5'h0D,
        5'h0D};
    localparam logic [8:0] TIM_LUT9 [32] = '{9'h00D, 9'h14F, 9'h057, 9'h00F, 9'h00F, 9'h001,
        9'h14D, 9'h00B, 9'h00D, 9'h001, 9'h079, 9'h09B, 9'h001, 9'h0AF, 9'h1A5, 9'h005, 9'h1FD,
        9'h0D7, 9'h02F, 9'h1A9, 9'h127, 9'h0E5, 9'h1AB, 9'h053, 9'h199, 9'h183, 9'h0C1, 9'h039,
        9'h1F5, 9'h139, 9'h1E9, 9'h187};
    // codeword length (12288 / rate) and mixer step per rate index 1/5 .. 6/7
    localparam logic [15:0] TIM_MX_LEN [14] = '{16'hF000, 16'hD800, 16'hC000, 16'hA800,
        16'hA000, 16'h9000, 16'h8000, 16'h7800, 16'h7000, 16'h6000, 16'h5000, 16'h4800,
        16'h4000, 16'h3800};
    localparam logic [7:0] TIM_MX_STEP [14] = '{8'hF7, 8'hF5, 8'hDD, 8'hC5, 8'hD1, 8'hB9,
        8'hB3, 8'hA7, 8'hA7, 8'h9D, 8'h95, 8'h7D, 8'h8B, 8'h71};
    localparam logic [3:0] TIM_SEL_RATE [28] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5,
        4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9, 4'hA, 4'hA, 4'hA, 4'hB, 4'hB,
        4'hB, 4'hC, 4'hC, 4'hC, 4'hD, 4'hD, 4'hD};
    localparam logic [1:0] TIM_SEL_PAT [28] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1,
        2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1,
        2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
endpackage

// ==== src/tim_mem_if.sv ====
// port bundle between the stream logic and a two-bank bit memory
`timescale 1ns/1ps
`default_nettype none
interface tim_mem_if #(parameter int AW = 14);
    logic wr_en;
    logic wr_bank;
    logic [AW-1:0] wr_addr;
    logic wr_data;
    logic rd_en;
    logic rd_bank;
    logic [AW-1:0] rd_addr;
    logic rd_data;
    modport user(output wr_en, wr_bank, wr_addr, wr_data, rd_en, rd_bank, rd_addr,
        input rd_data);
    modport mem(input wr_en, wr_bank, wr_addr, wr_data, rd_en, rd_bank, rd_addr,
        output rd_data);
endinterface
`default_nettype wire

// ==== src/tim_pingpong_mem.sv ====
// two-bank bit memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tim_pingpong_mem
    import tim_pkg::*;
#(
    parameter int AW = 14
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    tim_mem_if.mem port
);
    logic mem [2**(AW+1)];

    always_ff @(posedge mclk)
    begin
        if (port.wr_en)
        begin
            mem[{port.wr_bank, port.wr_addr}] <= port.wr_data;
        end
    end

    // read data holds while no read is issued, so a stalled consumer keeps its bit
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            port.rd_data <= 1'b0;
        end
        else if (port.rd_en)
        begin
            port.rd_data <= mem[{port.rd_bank, port.rd_addr}];
        end
    end
endmodule
`default_nettype wire

// ==== src/tim_mixer_top.sv ====
// turbo block interleaver, pattern selector decode and codeword mixer
`timescale 1ns/1ps
`default_nettype none
module tim_mixer_top
    import tim_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic il_large_block,
    input wire logic il_in_valid,
    input wire logic il_in_data,
    output logic il_in_ready,
    output logic il_out_valid,
    output logic il_out_data,
    output logic il_out_last,
    input wire logic il_out_ready,
    input wire logic [5:0] puncture_pattern_selector,
    input wire logic signalling_mode,
    input wire logic encoded_codeword_valid,
    input wire logic encoded_codeword_data,
    output logic encoded_codeword_ready,
    output logic mixed_valid,
    output logic mixed_data,
    output logic mixed_last,
    input wire logic mixed_ready,
    output logic [3:0] code_rate_index,
    output logic [1:0] pattern_type,
    output logic selector_reserved,
    output logic [7:0] mixer_step
);
    typedef struct packed {
        logic il_wbank;
        logic [13:0] il_wcnt;
        logic [1:0] il_full;
        logic [1:0] il_large;
        logic il_rbank;
        tim_rd_state_t il_st;
        logic [13:0] il_cnt;
        logic [13:0] il_emit;
        logic il_ovalid;
        logic il_olast;
        logic mx_wbank;
        logic [15:0] mx_wcnt;
        logic [1:0] mx_full;
        logic [1:0][15:0] mx_len;
        logic [1:0][7:0] mx_step;
        logic mx_rbank;
        tim_rd_state_t mx_st;
        logic [15:0] mx_idx;
        logic [15:0] mx_addr;
        logic mx_ovalid;
        logic mx_olast;
        logic [7:0] mx_ostep;
        logic [3:0] rate;
        logic [1:0] pat;
        logic rsv;
    } tim_state_t;

    tim_state_t st;
    tim_state_t next_st;
    tim_mem_if #(.AW(TIM_IL_AW)) ilm();
    tim_mem_if #(.AW(TIM_MX_AW)) mxm();

    tim_pingpong_mem #(.AW(TIM_IL_AW)) u_il_mem (.mclk(mclk), .sys_rst(sys_rst), .port(ilm));
    tim_pingpong_mem #(.AW(TIM_MX_AW)) u_mx_mem (.mclk(mclk), .sys_rst(sys_rst), .port(mxm));

    // {reserved, pattern, rate index}
    function automatic logic [6:0] tim_decode(input logic [5:0] sel);
        if (sel >= TIM_SEL_FIRST_RSV)
            return 7'h40;
        return {1'b0, TIM_SEL_PAT[sel[4:0]], TIM_SEL_RATE[sel[4:0]]};
    endfunction

    function automatic logic [4:0] tim_rev5(input logic [4:0] v);
        return {v[0], v[1], v[2], v[3], v[4]};
    endfunction

    logic [6:0] dec;
    logic il_rlarge;
    logic [13:0] il_rblk;
    logic [13:0] il_wblk;
    logic [4:0] hi5;
    logic [8:0] hi9;
    logic [9:0] p5;
    logic [17:0] p9;
    logic [13:0] il_cand;
    logic il_issue;
    logic il_can;
    logic [15:0] mx_wlen;
    logic [7:0] mx_wstep;
    logic [15:0] mx_rlen;
    logic [16:0] mx_sum;
    logic mx_issue;
    logic mx_can;

    always_comb
    begin
        dec = tim_decode(puncture_pattern_selector);
        il_rlarge = st.il_large[st.il_rbank];
        il_rblk = il_rlarge ? TIM_BLK_LARGE : TIM_BLK_SMALL;
        il_wblk = (st.il_wcnt == TIM_CNT_START ? il_large_block : st.il_large[st.il_wbank])
            ? TIM_BLK_LARGE : TIM_BLK_SMALL;
        hi5 = 5'(st.il_cnt[9:5] + 5'h01);
        hi9 = 9'(st.il_cnt[13:5] + 9'h001);
        p5 = {5'h00, hi5} * {5'h00, TIM_LUT5[st.il_cnt[4:0]]};
        p9 = {9'h000, hi9} * {9'h000, TIM_LUT9[st.il_cnt[4:0]]};
        il_cand = il_rlarge ? {tim_rev5(st.il_cnt[4:0]), p9[8:0]}
            : {4'h0, tim_rev5(st.il_cnt[4:0]), p5[4:0]};
        // signalling ignores the selector and always frames 3840 bits with step 61
        mx_wlen = signalling_mode ? TIM_SIG_LEN : TIM_MX_LEN[dec[3:0]];
        mx_wstep = signalling_mode ? TIM_SIG_STEP : TIM_MX_STEP[dec[3:0]];
        mx_rlen = st.mx_len[st.mx_rbank];
        mx_sum = {1'b0, st.mx_addr} + {9'h000, st.mx_step[st.mx_rbank]};
        il_can = !st.il_ovalid || il_out_ready;
        mx_can = !st.mx_ovalid || mixed_ready;
        il_issue = 1'b0;
        mx_issue = 1'b0;
        next_st = st;
        next_st.rate = dec[3:0];
        next_st.pat = dec[5:4];
        next_st.rsv = dec[6];

        // interleaver fill side
        il_in_ready = !st.il_full[st.il_wbank];
        if (il_in_valid && il_in_ready)
        begin
            next_st.il_wcnt = 14'(st.il_wcnt + 14'h0001);
            if (st.il_wcnt == TIM_CNT_START)
                next_st.il_large[st.il_wbank] = il_large_block;
            if (st.il_wcnt == 14'(il_wblk - 14'h0001))
            begin
                next_st.il_full[st.il_wbank] = 1'b1;
                next_st.il_wbank = !st.il_wbank;
                next_st.il_wcnt = TIM_CNT_START;
            end
        end
        // interleaver drain side
        case (st.il_st)
            TIM_RD_IDLE:
                if (st.il_full[st.il_rbank])
                begin
                    next_st.il_st = TIM_RD_RUN;
                    next_st.il_cnt = TIM_CNT_START;
                    next_st.il_emit = TIM_CNT_START;
                end
            TIM_RD_RUN:
                if (il_can)
                begin
                    next_st.il_cnt = 14'(st.il_cnt + 14'h0001);
                    if (il_cand < il_rblk)
                    begin
                        il_issue = 1'b1;
                        next_st.il_emit = 14'(st.il_emit + 14'h0001);
                        next_st.il_olast = st.il_emit == 14'(il_rblk - 14'h0001);
                        if (next_st.il_olast)
                        begin
                            next_st.il_st = TIM_RD_IDLE;
                            next_st.il_full[st.il_rbank] = 1'b0;
                            next_st.il_rbank = !st.il_rbank;
                        end
                    end
                end
            default:
                next_st.il_st = TIM_RD_IDLE;
        endcase
        if (il_issue)
            next_st.il_ovalid = 1'b1;
        else if (il_out_ready)
            next_st.il_ovalid = 1'b0;

        // mixer fill side; a reserved selector holds off a new service codeword
        encoded_codeword_ready = !st.mx_full[st.mx_wbank] && !(st.mx_wcnt == 16'h0000
            && dec[6] && !signalling_mode);
        if (encoded_codeword_valid && encoded_codeword_ready)
        begin
            next_st.mx_wcnt = 16'(st.mx_wcnt + 16'h0001);
            if (st.mx_wcnt == 16'h0000)
            begin
                next_st.mx_len[st.mx_wbank] = mx_wlen;
                next_st.mx_step[st.mx_wbank] = mx_wstep;
            end
            if (st.mx_wcnt == 16'((st.mx_wcnt == 16'h0000 ? mx_wlen
                : st.mx_len[st.mx_wbank]) - 16'h0001))
            begin
                next_st.mx_full[st.mx_wbank] = 1'b1;
                next_st.mx_wbank = !st.mx_wbank;
                next_st.mx_wcnt = 16'h0000;
            end
        end
        // mixer drain side
        case (st.mx_st)
            TIM_RD_IDLE:
                if (st.mx_full[st.mx_rbank])
                begin
                    next_st.mx_st = TIM_RD_RUN;
                    next_st.mx_idx = 16'h0000;
                    next_st.mx_addr = 16'h0000;
                end
            TIM_RD_RUN:
                if (mx_can)
                begin
                    mx_issue = 1'b1;
                    next_st.mx_ostep = st.mx_step[st.mx_rbank];
                    next_st.mx_idx = 16'(st.mx_idx + 16'h0001);
                    next_st.mx_addr = (mx_sum >= {1'b0, mx_rlen}) ? 16'(mx_sum - {1'b0, mx_rlen})
                        : mx_sum[15:0];
                    next_st.mx_olast = st.mx_idx == 16'(mx_rlen - 16'h0001);
                    if (next_st.mx_olast)
                    begin
                        next_st.mx_st = TIM_RD_IDLE;
                        next_st.mx_full[st.mx_rbank] = 1'b0;
                        next_st.mx_rbank = !st.mx_rbank;
                    end
                end
            default:
                next_st.mx_st = TIM_RD_IDLE;
        endcase
        if (mx_issue)
            next_st.mx_ovalid = 1'b1;
        else if (mixed_ready)
            next_st.mx_ovalid = 1'b0;

        ilm.wr_en = il_in_valid && il_in_ready;
        ilm.wr_bank = st.il_wbank;
        ilm.wr_addr = st.il_wcnt;
        ilm.wr_data = il_in_data;
        ilm.rd_en = il_issue;
        ilm.rd_bank = st.il_rbank;
        ilm.rd_addr = il_cand;
        mxm.wr_en = encoded_codeword_valid && encoded_codeword_ready;
        mxm.wr_bank = st.mx_wbank;
        mxm.wr_addr = st.mx_wcnt;
        mxm.wr_data = encoded_codeword_data;
        mxm.rd_en = mx_issue;
        mxm.rd_bank = st.mx_rbank;
        mxm.rd_addr = st.mx_addr;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.il_st <= TIM_RD_IDLE;
            st.mx_st <= TIM_RD_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign il_out_valid = st.il_ovalid;
    assign il_out_data = ilm.rd_data;
    assign il_out_last = st.il_olast;
    assign mixed_valid = st.mx_ovalid;
    assign mixed_data = mxm.rd_data;
    assign mixed_last = st.mx_olast;
    assign code_rate_index = st.rate;
    assign pattern_type = st.pat;
    assign selector_reserved = st.rsv;
    assign mixer_step = st.mx_ostep;

    a_il_cnt_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(st.il_st == TIM_RD_RUN) |-> st.il_cnt == 14'h0000)
        else $error("address counter not cleared at block start");
    a_il_first_addr: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(st.il_st == TIM_RD_RUN) |-> il_cand == (il_rlarge ? 14'h000D : 14'h001B))
        else $error("first interleaver candidate wrong");
    a_il_read_bound: assert property (@(posedge mclk) disable iff (sys_rst)
        il_issue |-> il_cand < il_rblk && st.il_emit < il_rblk)
        else $error("interleaver read beyond block");
    a_il_out_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        il_out_valid && !il_out_ready |=> il_out_valid && $stable(il_out_data))
        else $error("interleaver output changed while stalled");
    a_il_both_full: assert property (@(posedge mclk) disable iff (sys_rst)
        st.il_full == 2'h3 |-> !il_in_ready)
        else $error("interleaver accepts with both buffers full");
    a_mx_first_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(st.mx_st == TIM_RD_RUN) |-> st.mx_addr == 16'h0000 ##1 !mx_can || mx_issue)
        else $error("mixer codeword does not start at bit zero");
    a_mx_addr_bound: assert property (@(posedge mclk) disable iff (sys_rst)
        mx_issue |-> st.mx_addr < mx_rlen && st.mx_idx < mx_rlen)
        else $error("mixer read beyond codeword");
    a_sig_cfg: assert property (@(posedge mclk) disable iff (sys_rst)
        signalling_mode && mxm.wr_en && st.mx_wcnt == 16'h0000 |=>
        st.mx_len[$past(st.mx_wbank)] == TIM_SIG_LEN
        && st.mx_step[$past(st.mx_wbank)] == TIM_SIG_STEP)
        else $error("signalling codeword not framed at 3840 with step 61");
    a_sel_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
        puncture_pattern_selector >= TIM_SEL_FIRST_RSV |=> selector_reserved)
        else $error("reserved selector not flagged");
    a_sel_rate_len: assert property (@(posedge mclk) disable iff (sys_rst)
        puncture_pattern_selector == TIM_SIG_SELECTOR |=> code_rate_index == 4'h0
        && pattern_type == 2'h0)
        else $error("selector 0 not decoded as standard 1/5");
endmodule
`default_nettype wire

// ==== testbench/tim_sink_model.sv ====
// downstream segmenter stand-in: takes a bit stream and stalls on request
`timescale 1ns/1ps
`default_nettype none
module tim_sink_model
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic coin,
    output logic ready
);
    // a slow sink stalls on coin flips so that held output bits get exercised
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            ready <= 1'b0;
        else
            ready <= !slow || coin;
    end
endmodule
`default_nettype wire

// ==== testbench/tim_mixer_top_tb_top.sv ====
// self-checking bench for the interleaver, selector decode and mixer
`timescale 1ns/1ps
`default_nettype none
module tim_mixer_top_tb_top;
    import tim_pkg::*;
    logic mclk, sys_rst, il_large_block, il_in_valid, il_in_data, il_in_ready, il_out_valid;
    logic il_out_data, il_out_last, il_out_ready, signalling_mode, encoded_codeword_valid;
    logic encoded_codeword_data, encoded_codeword_ready, mixed_valid, mixed_data, mixed_last;
    logic mixed_ready, selector_reserved, coin_il, coin_mx, mx_slow;
    logic [5:0] puncture_pattern_selector;
    logic [3:0] code_rate_index;
    logic [1:0] pattern_type;
    logic [7:0] mixer_step;
    int bad_count, cmp_count, r, p, rv, e_il, e_mx;
    int il_q[$];
    int mx_q[$];
    logic [31:0] seed = 32'h00000017;
    int lut5[32] = '{27, 3, 1, 15, 13, 17, 23, 13, 9, 3, 15, 3, 13, 1, 13, 29, 21, 19, 1, 3, 29,
        17, 25, 29, 9, 13, 23, 13, 13, 1, 13, 13};
    int lut9[32] = '{13, 335, 87, 15, 15, 1, 333, 11, 13, 1, 121, 155, 1, 175, 421, 5, 509, 215,
        47, 425, 295, 229, 427, 83, 409, 387, 193, 57, 501, 313, 489, 391};

    tim_mixer_top tim_mixer_top_inst (.mclk(mclk), .sys_rst(sys_rst),
        .il_large_block(il_large_block), .il_in_valid(il_in_valid), .il_in_data(il_in_data),
        .il_in_ready(il_in_ready), .il_out_valid(il_out_valid), .il_out_data(il_out_data),
        .il_out_last(il_out_last), .il_out_ready(il_out_ready),
        .puncture_pattern_selector(puncture_pattern_selector), .signalling_mode(signalling_mode),
        .encoded_codeword_valid(encoded_codeword_valid),
        .encoded_codeword_data(encoded_codeword_data),
        .encoded_codeword_ready(encoded_codeword_ready), .mixed_valid(mixed_valid),
        .mixed_data(mixed_data), .mixed_last(mixed_last), .mixed_ready(mixed_ready),
        .code_rate_index(code_rate_index), .pattern_type(pattern_type),
        .selector_reserved(selector_reserved), .mixer_step(mixer_step));
    tim_sink_model tim_sink_model_inst (.mclk(mclk), .sys_rst(sys_rst), .slow(1'b1),
        .coin(coin_il), .ready(il_out_ready));
    tim_sink_model tim_sink_model_inst2 (.mclk(mclk), .sys_rst(sys_rst), .slow(mx_slow),
        .coin(coin_mx), .ready(mixed_ready));

    function automatic logic rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[0];
    endfunction

    function automatic int rev5(int x);
        int y;
        y = 0;
        for (int b = 0; b < 5; b++)
            y = (y << 1) | ((x >> b) & 1);
        return y;
    endfunction

    task automatic chk_bit(string name, logic exp, logic got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_dec(string name, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // expected order is built before sending, so outputs can never outrun the queue
    task automatic run_il(input int lg);
        int nb, n, k, a;
        bit blk[$];
        nb = lg ? 12282 : 762;
        n = lg ? 9 : 5;
        k = 0;
        for (int i = 0; i < nb; i++)
            blk.push_back(rnd());
        for (int c = 0; k < nb; c++)
        begin
            a = (((c >> 5) + 1) % (1 << n)) * (lg ? lut9[c % 32] : lut5[c % 32]);
            a = (rev5(c % 32) << n) | (a % (1 << n));
            if (a < nb)
            begin
                il_q.push_back(int'(blk[a]) | int'(k == nb - 1) * 2);
                k++;
            end
        end
        for (int i = 0; i < nb; i++)
        begin
            il_in_valid <= 1'b1;
            il_in_data <= blk[i];
            il_large_block <= lg[0];
            do @(negedge mclk); while (il_in_ready !== 1'b1);
            @(posedge mclk);
        end
    endtask

    task automatic run_mx(input int sig, input int len, input int step, input int nsel);
        bit cw[$];
        for (int i = 0; i < len; i++)
            cw.push_back(rnd());
        for (int i = 0; i < len; i++)
            mx_q.push_back(int'(cw[(step * i) % len]) | int'(i == len - 1) * 2 | step * 4);
        for (int i = 0; i < len; i++)
        begin
            encoded_codeword_valid <= 1'b1;
            encoded_codeword_data <= cw[i];
            signalling_mode <= sig[0];
            if (i == len / 2)
                puncture_pattern_selector <= 6'(nsel);
            do @(negedge mclk); while (encoded_codeword_ready !== 1'b1);
            @(posedge mclk);
        end
    endtask

    always @(posedge mclk)
    begin
        coin_il <= rnd();
        coin_mx <= rnd();
        if (!sys_rst && il_out_valid === 1'b1 && il_out_ready === 1'b1)
        begin
            e_il = (il_q.size() > 0) ? il_q.pop_front() : 4;
            chk_bit("il_data", e_il[0], il_out_data);
            chk_bit("il_last", e_il[1], il_out_last);
            chk_bit("il_extra", 1'b0, e_il[2]);
        end
        if (!sys_rst && mixed_valid === 1'b1 && mixed_ready === 1'b1)
        begin
            e_mx = (mx_q.size() > 0) ? mx_q.pop_front() : 0;
            chk_bit("mx_data", e_mx[0], mixed_data);
            chk_bit("mx_last", e_mx[1], mixed_last);
            chk_dec("mx_step", e_mx[9:2], mixer_step);
        end
    end

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        repeat (90000) @(posedge mclk);
        chk_bit("watchdog", 1'b0, 1'b1);
        close_out();
    end

    initial
    begin
        sys_rst = 1'b1;
        {il_large_block, il_in_valid, il_in_data, signalling_mode} = 4'h0;
        {encoded_codeword_valid, encoded_codeword_data, mx_slow, coin_il, coin_mx} = 5'h00;
        puncture_pattern_selector = 6'h00;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int s = 0; s < 64; s++)
        begin
            puncture_pattern_selector <= 6'(s);
            repeat (2) @(posedge mclk);
            #1;
            rv = int'(s >= 28);
            r = rv ? 0 : s < 6 ? s : s < 13 ? 5 + (s - 5) / 2 : 9 + (s - 13) / 3;
            p = (rv || s < 6) ? 0 : s < 13 ? int'(s % 2 == 0) : (s - 13) % 3;
            chk_dec("rate", 8'(r), {4'h0, code_rate_index});
            chk_dec("pattern", 8'(p), {6'h00, pattern_type});
            chk_dec("reserved", 8'(rv), {7'h00, selector_reserved});
        end
        encoded_codeword_valid <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk_bit("refuse_rsv", 1'b0, encoded_codeword_ready);
        encoded_codeword_valid <= 1'b0;
        puncture_pattern_selector <= 6'h00;
        repeat (2) @(posedge mclk);
        fork
            begin
                run_il(0);
                run_il(1);
                il_in_valid <= 1'b0;
            end
            begin
                run_mx(1, 3840, 61, 25);
                mx_slow <= 1'b1;
                run_mx(0, 14336, 113, 25);
                encoded_codeword_valid <= 1'b0;
            end
        join
        for (int w = 0; w < 60000 && (il_q.size() > 0 || mx_q.size() > 0); w++)
            @(posedge mclk);
        repeat (20) @(posedge mclk);
        chk_dec("il_left", 8'h00, 8'(il_q.size() != 0));
        chk_dec("mx_left", 8'h00, 8'(mx_q.size() != 0));
        close_out();
    end
endmodule
`default_nettype wire
